/* File: bps_bridge_steer.sv */
// Enhanced PWM output mode mapping: single, half-bridge and full-bridge
// Operation
// R1 - Mode field 00 single, 10 half, 01 full forward, 11 full reverse.
// R2 - Half-bridge uses only outputs A and B; C and D not driven.
// R3 - Half-bridge drives PWM on A and its complement on B.
// R4 - Half-bridge delays each output's turn-on by the dead-band count.
// R5 - Dead-band delay lasts four oscillator periods per count.
// R6 - Dead band longer than active time keeps output inactive all period.
// R7 - Both full-bridge modes drive all four outputs.
// R8 - Forward: A active, D modulated, B and C inactive.
// R9 - Reverse: C active, B modulated, A and D inactive.
// R10 - Direction bit change takes effect from the next PWM period.
// R11 - On direction change, B and D forced inactive four counts before end.
// R12 - At that point A and C switch to the opposite direction levels.
// R13 - Modulation of the new output resumes at the next period start.
// R14 - No dead band in either full-bridge mode.
// R15 - Firmware lowers duty for one period before reversing near full duty.
// R16 - Single mode steers PWM to any of A to D individually.
// R17 - Firmware clears pin direction bits for used outputs.
// R18 - Polarity chosen separately for pair A/C and pair B/D.
// R19 - Timing comes from period-start, duty-match events and the clock.
// R20 - Reset restores settings and drives no PWM activity.
module bps_bridge_steer
  import bps_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic period_start,
  input wire logic duty_match,
  input wire logic [BPS_TMR_W-1:0] timer_count,
  input wire logic [BPS_TMR_W-1:0] period_end_count,
  input wire logic [1:0] bridge_mode_select,
  input wire logic [BPS_DB_W-1:0] deadband_count,
  input wire logic [1:0] output_polarity_select,
  input wire logic [3:0] steer_enable,
  output logic output_a,
  output logic output_b,
  output logic output_c,
  output logic output_d,
  output logic [3:0] output_a_d_enable,
  output logic dir_reverse
);
  bps_mode_t mode_r, mode_nxt;
  logic pwm_r, pwm_nxt;
  logic rev_r, rev_nxt;
  logic turn_r, turn_nxt;
  logic started_r, started_nxt;
  logic [3:0] pin_r, pin_nxt;
  logic [3:0] en_r, en_nxt;
  logic lead_hit;
  bps_mode_t req_mode;
  bps_db_if db_a ();
  bps_db_if db_b ();

  assign req_mode = bps_decode(bridge_mode_select); // see R1
  // Hazard window starts four timer counts before the period wraps
  assign lead_hit = (timer_count + BPS_TMR_W'(BPS_REV_LEAD_COUNTS)) ==
                    (period_end_count + BPS_TMR_W'(1));

  always_comb begin
    mode_nxt = mode_r;
    pwm_nxt = pwm_r;
    rev_nxt = rev_r;
    turn_nxt = turn_r;
    started_nxt = started_r;
    // Raw waveform from the shared generator events (see R19)
    if (period_start) begin
      pwm_nxt = 1'b1;
      started_nxt = 1'b1;
    end else if (duty_match) begin
      pwm_nxt = 1'b0;
    end
    if (req_mode == BPS_FWD || req_mode == BPS_REV) begin
      if (mode_r != BPS_FWD && mode_r != BPS_REV) begin
        mode_nxt = req_mode;
        rev_nxt = (req_mode == BPS_REV);
      end else if ((req_mode == BPS_REV) != rev_r && lead_hit) begin
        turn_nxt = 1'b1; // see R11
        rev_nxt = (req_mode == BPS_REV); // see R12
      end
      if (period_start) begin
        turn_nxt = 1'b0; // see R13
        mode_nxt = rev_nxt ? BPS_REV : BPS_FWD; // see R10
      end
    end else begin
      // Non-bridge modes switch immediately; no turnaround to manage
      mode_nxt = req_mode;
      turn_nxt = 1'b0;
    end
  end

  assign db_a.level = started_r && mode_r == BPS_HALF && pwm_r; // see R3
  assign db_b.level = started_r && mode_r == BPS_HALF && !pwm_r; // see R3
  assign db_a.count = deadband_count;
  assign db_b.count = deadband_count;

  bps_deadband u_db_a (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .ch(db_a)
  );
  bps_deadband u_db_b (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .ch(db_b)
  );

  always_comb begin
    logic act_a, act_b, act_c, act_d, mod;
    act_a = 1'b0;
    act_b = 1'b0;
    act_c = 1'b0;
    act_d = 1'b0;
    mod = started_r && pwm_r && !turn_r;
    en_nxt = 4'h0;
    unique case (mode_r)
      BPS_SINGLE: begin
        en_nxt = steer_enable; // see R16
        act_a = started_r && pwm_r;
        act_b = started_r && pwm_r;
        act_c = started_r && pwm_r;
        act_d = started_r && pwm_r;
      end
      BPS_HALF: begin
        en_nxt = 4'h3; // see R2
        act_a = db_a.delayed; // see R4
        act_b = db_b.delayed;
      end
      BPS_FWD, BPS_REV: begin
        en_nxt = 4'hF; // see R7
        // No dead band here; direction switch uses the turnaround gap
        act_a = !rev_r; // see R14
        act_c = rev_r; // see R12
        act_d = (mode_r == BPS_FWD) && mod; // see R8
        act_b = (mode_r == BPS_REV) && mod; // see R9
      end
    endcase
    // High polarity bits give active-low per pair (see R18)
    pin_nxt[0] = act_a ^ output_polarity_select[1];
    pin_nxt[2] = act_c ^ output_polarity_select[1];
    pin_nxt[1] = act_b ^ output_polarity_select[0];
    pin_nxt[3] = act_d ^ output_polarity_select[0];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= BPS_SINGLE; // see R20
      pwm_r <= 1'b0;
      rev_r <= 1'b0;
      turn_r <= 1'b0;
      started_r <= 1'b0;
      pin_r <= 4'h0;
      en_r <= 4'h0;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      pwm_r <= pwm_nxt;
      rev_r <= rev_nxt;
      turn_r <= turn_nxt;
      started_r <= started_nxt;
      pin_r <= pin_nxt;
      en_r <= en_nxt;
    end
  end

  assign output_a = pin_r[0];
  assign output_b = pin_r[1];
  assign output_c = pin_r[2];
  assign output_d = pin_r[3];
  assign output_a_d_enable = en_r;
  assign dir_reverse = rev_r;

  a_half_pins: assert property (@(posedge clock) disable iff (rst)
    clk_en && mode_r == BPS_HALF |=> en_r == 4'h3) // see R2
    else $error("half bridge enabled C or D");
  a_full_pins: assert property (@(posedge clock) disable iff (rst)
    clk_en && (mode_r == BPS_FWD || mode_r == BPS_REV) |=> en_r == 4'hF) // see R7
    else $error("full bridge not driving all pins");
  a_fwd_levels: assert property (@(posedge clock) disable iff (rst)
    clk_en && mode_r == BPS_FWD && !rev_r |=>
      pin_r[0] == !$past(output_polarity_select[1])
      && pin_r[2] == $past(output_polarity_select[1])
      && pin_r[1] == $past(output_polarity_select[0])) // see R8
    else $error("forward levels wrong");
  a_rev_levels: assert property (@(posedge clock) disable iff (rst)
    clk_en && mode_r == BPS_REV && rev_r |=>
      pin_r[2] == !$past(output_polarity_select[1])
      && pin_r[0] == $past(output_polarity_select[1])
      && pin_r[3] == $past(output_polarity_select[0])) // see R9
    else $error("reverse levels wrong");
  a_turn_quiet: assert property (@(posedge clock) disable iff (rst)
    clk_en && turn_r |=> pin_r[1] == $past(output_polarity_select[0])
      && pin_r[3] == $past(output_polarity_select[0])) // see R11
    else $error("modulated output active during turnaround");
  a_turn_ends: assert property (@(posedge clock) disable iff (rst)
    clk_en && period_start && (mode_r == BPS_FWD || mode_r == BPS_REV) |=> !turn_r) // see R13
    else $error("turnaround outlived period");
  a_dir_apply: assert property (@(posedge clock) disable iff (rst)
    clk_en && turn_r && period_start && (req_mode == BPS_FWD || req_mode == BPS_REV)
      |=> (mode_r == BPS_REV) == rev_r) // see R10
    else $error("direction not applied at period start");
  a_steer_en: assert property (@(posedge clock) disable iff (rst)
    clk_en && mode_r == BPS_SINGLE |=> en_r == $past(steer_enable)) // see R16
    else $error("steering enables wrong");
  a_half_comp: assert property (@(posedge clock) disable iff (rst)
    clk_en && mode_r == BPS_HALF |=> !((pin_r[0] ^ $past(output_polarity_select[1]))
      && (pin_r[1] ^ $past(output_polarity_select[0])))) // see R3
    else $error("half bridge outputs active together");
  a_lead_turn: assert property (@(posedge clock) disable iff (rst)
    clk_en && lead_hit && !period_start && (mode_r == BPS_FWD || mode_r == BPS_REV)
      && (req_mode == BPS_FWD || req_mode == BPS_REV) && ((req_mode == BPS_REV) != rev_r)
      |=> turn_r && rev_r != $past(rev_r)) // see R11
    else $error("turnaround not started at lead point");
  a_full_nodb: assert property (@(posedge clock) disable iff (rst)
    clk_en && mode_r == BPS_FWD && started_r && pwm_r && !turn_r |=>
      pin_r[3] == !$past(output_polarity_select[0])) // see R14
    else $error("full bridge output delayed");

  c_half: cover property (@(posedge clock) mode_r == BPS_HALF && db_a.delayed);
  c_turn: cover property (@(posedge clock) turn_r ##1 !turn_r);
  c_steer: cover property (@(posedge clock) mode_r == BPS_SINGLE && en_r == 4'hF);
  c_back_fwd: cover property (@(posedge clock) rev_r ##1 !rev_r);
  c_frozen: cover property (@(posedge clock) !clk_en && period_start);
endmodule // bps_bridge_steer

/* File: bps_pkg.sv */
// Package of constants and types for the bridge PWM output steering block
package bps_pkg;
  localparam int unsigned BPS_CLK_MHZ = 100;
  localparam int unsigned BPS_DB_W = 7;
  localparam int unsigned BPS_DB_OSC_PER_UNIT = 4;
  localparam int unsigned BPS_DB_CNT_W = 9;
  localparam int unsigned BPS_REV_LEAD_COUNTS = 4;
  localparam int unsigned BPS_TMR_W = 10;
  localparam logic [1:0] BPS_MODE_SINGLE = 2'h0;
  localparam logic [1:0] BPS_MODE_FWD = 2'h1;
  localparam logic [1:0] BPS_MODE_HALF = 2'h2;
  localparam logic [1:0] BPS_MODE_REV = 2'h3;
  localparam logic [BPS_DB_CNT_W-1:0] BPS_DB_CNT_ZERO = 9'h000;
  localparam logic [BPS_DB_CNT_W-1:0] BPS_DB_CNT_ONE = 9'h001;
  typedef enum logic [1:0] {
    BPS_SINGLE,
    BPS_HALF,
    BPS_FWD,
    BPS_REV
  } bps_mode_t;
  function automatic bps_mode_t bps_decode(input logic [1:0] sel);
    unique case (sel)
      BPS_MODE_SINGLE: bps_decode = BPS_SINGLE;
      BPS_MODE_HALF: bps_decode = BPS_HALF;
      BPS_MODE_FWD: bps_decode = BPS_FWD;
      default: bps_decode = BPS_REV;
    endcase
  endfunction
endpackage

/* File: bps_db_if.sv */
// Interface carrying one dead-band delay channel request and result
interface bps_db_if;
  import bps_pkg::*;
  logic level;
  logic [BPS_DB_W-1:0] count;
  logic delayed;
  modport owner (output level, output count, input delayed);
  modport delay (input level, input count, output delayed);
endinterface

/* File: bps_deadband.sv */
// Rising-edge dead-band delay for one half-bridge output
module bps_deadband
  import bps_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  bps_db_if.delay ch
);
  logic [BPS_DB_CNT_W-1:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (!ch.level) begin
      // Falling edge passes at once; only turn-on is delayed
      out_nxt = 1'b0;
      cnt_nxt = BPS_DB_CNT_ZERO;
    end else if (!out_r) begin
      // Each count unit is four oscillator periods (see R5)
      if (cnt_r >= BPS_DB_CNT_W'(ch.count) * BPS_DB_CNT_W'(BPS_DB_OSC_PER_UNIT)) begin // see R4
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + BPS_DB_CNT_ONE; // see R6
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= BPS_DB_CNT_ZERO;
      out_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign ch.delayed = out_r;

  a_db_no_early: assert property (@(posedge clock) disable iff (rst)
    clk_en && $rose(out_r) |-> $past(ch.level) && $past(cnt_r) >= 
      BPS_DB_CNT_W'($past(ch.count)) * BPS_DB_CNT_W'(BPS_DB_OSC_PER_UNIT)) // see R4
    else $error("dead band ended early");
  a_db_fall_fast: assert property (@(posedge clock) disable iff (rst)
    clk_en && !ch.level |=> !out_r) // see R6
    else $error("output stayed active after waveform fell");
endmodule // bps_deadband

/* File: bps_switch_model.sv */
// Behavioural model of the external bridge power switch drivers
module bps_switch_model (
  input wire logic clock,
  input wire logic [3:0] pin_level,
  input wire logic [3:0] pin_drive,
  input wire logic [1:0] active_low,
  output logic [3:0] pad,
  output int shoot_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sw_on;
  logic [1:0] pol_seen;
  // Undriven pins fall to the pull-down on each gate input
  assign pad = pin_level & pin_drive;
  // Polarity is seen one clock late, in step with the registered pins it qualifies
  assign sw_on = (pad ^ {pol_seen[0], pol_seen[1], pol_seen[0], pol_seen[1]}) & pin_drive;
  initial shoot_count = 0;
  // Both switches of one leg on at once would short the supply
  always @(posedge clock) begin
    pol_seen <= active_low;
    if ((sw_on[0] && sw_on[1]) || (sw_on[2] && sw_on[3])) begin
      shoot_count++;
    end
  end
endmodule // bps_switch_model

/* File: bps_bridge_steer_test.sv */
// Self-checking bench for the bridge PWM output steering block
module bps_bridge_steer_test;
  import bps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, clk_en, period_start, duty_match, dir_reverse;
  logic output_a, output_b, output_c, output_d;
  logic [BPS_TMR_W-1:0] timer_count, period_end_count;
  logic [1:0] bridge_mode_select, output_polarity_select;
  logic [BPS_DB_W-1:0] deadband_count;
  logic [3:0] steer_enable, output_a_d_enable, pad;
  logic [3:0] snap [0:39];
  int shoot_count, fail_count, tests_run;
  bps_bridge_steer bps_bridge_steer_inst (.clock(clock), .rst(rst), .clk_en(clk_en),
    .period_start(period_start), .duty_match(duty_match), .timer_count(timer_count),
    .period_end_count(period_end_count), .bridge_mode_select(bridge_mode_select),
    .deadband_count(deadband_count), .output_polarity_select(output_polarity_select),
    .steer_enable(steer_enable), .output_a(output_a), .output_b(output_b),
    .output_c(output_c), .output_d(output_d), .output_a_d_enable(output_a_d_enable),
    .dir_reverse(dir_reverse));
  bps_switch_model bps_switch_model_inst (.clock(clock),
    .pin_level({output_d, output_c, output_b, output_a}), .pin_drive(output_a_d_enable),
    .active_low(output_polarity_select), .pad(pad), .shoot_count(shoot_count));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Periods of 40 counts; settings change mid-period so a stale period start is exercised
  task automatic run(input logic [1:0] mode, input logic [6:0] db, input logic [1:0] pol,
      input int duty, input int reps);
    for (int p = 0; p < reps; p++) begin
      for (int k = 0; k < 40; k++) begin
        @(posedge clock);
        timer_count <= BPS_TMR_W'(k);
        period_start <= (k == 0);
        duty_match <= (k == duty);
        if (k == 5) begin
          bridge_mode_select <= mode;
          deadband_count <= db;
          output_polarity_select <= pol;
        end
        @(negedge clock);
        snap[k] = pad;
      end
    end
  endtask
  initial begin
    fail_count = 0;
    tests_run = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    period_start = 1'b0;
    duty_match = 1'b0;
    timer_count = '0;
    period_end_count = 10'h027;
    bridge_mode_select = 2'h0;
    deadband_count = 7'h00;
    output_polarity_select = 2'h0;
    steer_enable = 4'h5;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk("reset pins", 4'h0, {output_d, output_c, output_b, output_a});
    chk("reset enables", 4'h0, output_a_d_enable);
    chk("reset direction", 4'h0, {3'h0, dir_reverse});
    @(posedge clock);
    rst <= 1'b0;
    run(2'h0, 7'h00, 2'h0, 20, 2);
    chk("single active", 4'h5, snap[10]);
    chk("single idle", 4'h0, snap[30]);
    chk("single enables", 4'h5, output_a_d_enable);
    run(2'h2, 7'h00, 2'h0, 20, 2);
    chk("half active", 4'h1, snap[10]);
    chk("half complement", 4'h2, snap[30]);
    chk("half enables", 4'h3, output_a_d_enable);
    run(2'h2, 7'h03, 2'h0, 20, 2);
    chk("deadband hold", 4'h0, snap[12]);
    chk("deadband end", 4'h1, snap[17]);
    chk("deadband b hold", 4'h0, snap[25]);
    run(2'h2, 7'h7F, 2'h0, 20, 2);
    chk("long deadband a", 4'h0, snap[10]);
    chk("long deadband b", 4'h0, snap[30]);
    run(2'h1, 7'h7F, 2'h0, 20, 2);
    chk("forward active", 4'h9, snap[10]);
    chk("forward idle", 4'h1, snap[30]);
    chk("full enables", 4'hF, output_a_d_enable);
    run(2'h1, 7'h7F, 2'h2, 20, 2);
    chk("polarity pairs", 4'hC, snap[10]);
    // Waveform still active at the lead point, so the blanking of D is visible
    run(2'h3, 7'h7F, 2'h0, 37, 1);
    chk("old direction kept", 4'h9, snap[28]);
    chk("lead not early", 4'h9, snap[37]);
    chk("lead switch", 4'h4, snap[38]);
    chk("lead unmodulated", 4'h4, snap[39]);
    chk("direction flag", 4'h1, {3'h0, dir_reverse});
    run(2'h3, 7'h7F, 2'h0, 20, 1);
    chk("reverse active", 4'h6, snap[10]);
    chk("reverse idle", 4'h4, snap[30]);
    run(2'h1, 7'h7F, 2'h0, 20, 1);
    chk("back to forward", 4'h1, snap[38]);
    chk("forward flag", 4'h0, {3'h0, dir_reverse});
    // A period start while the clock enable is low must leave the pins alone
    @(posedge clock);
    clk_en <= 1'b0;
    period_start <= 1'b1;
    repeat (3) @(posedge clock);
    period_start <= 1'b0;
    @(negedge clock);
    chk("frozen pins", 4'h1, pad);
    chk("no shoot through", 4'h0, (shoot_count == 0) ? 4'h0 : 4'h1);
    test_done();
  end
endmodule // bps_bridge_steer_test
